// *** core/cpu_core_register_set.v ***
`timescale 1ns/1ns
`include "cpu_regs_consts.vh"
module cpu_core_register_set #(
    parameter DW = `DATA_W
) (
    input wire clk_sys,
    input wire rst,
    input wire [`GPR_IDX_W-1:0] rd_a_idx,
    input wire [`GPR_IDX_W-1:0] rd_b_idx,
    output wire [DW-1:0] rd_a_data,
    output wire [DW-1:0] rd_b_data,
    input wire gpr_wr_en,
    input wire [`GPR_IDX_W-1:0] gpr_wr_idx,
    input wire [DW-1:0] gpr_wr_data,
    input wire cr_wr_en,
    input wire [`CR_SEL_W-1:0] cr_wr_sel,
    input wire [DW-1:0] cr_wr_data,
    input wire [`CR_SEL_W-1:0] cr_rd_sel,
    output reg [DW-1:0] cr_rd_data,
    input wire pc_load_en,
    input wire [DW-1:0] pc_load_addr,
    input wire fast_irq_take,
    input wire [DW-1:0] vec_index,
    output wire [DW-1:0] vec_entry_addr,
    input wire [`ACC_OP_W-1:0] acc_op,
    input wire [DW-1:0] acc_opnd_a,
    input wire [DW-1:0] acc_opnd_b,
    output wire [DW-1:0] acc_upper_half,
    output wire [DW-1:0] acc_middle_half,
    output wire [2*DW-1:0] wide_product_sum_reg,
    output wire [DW-1:0] stack_pointer,
    output wire [DW-1:0] instruction_pointer,
    output wire [DW-1:0] cpu_status_word
);
    // ****************************************
    // register storage
    // ****************************************
    reg [DW-1:0] gpr_mem [1:`GPR_COUNT-1];
    reg [DW-1:0] irq_stack_pointer_reg;
    reg [DW-1:0] task_stack_pointer_reg;
    reg [DW-1:0] vector_table_base_reg;
    reg [DW-1:0] pc_reg;
    reg [DW-1:0] sw_reg;
    reg [DW-1:0] saved_instruction_pointer_reg;
    reg [DW-1:0] saved_cpu_status_word_reg;
    reg [DW-1:0] fast_irq_target_reg;
    // the status bit picks the stack bank for both read ports and the write path
    wire task_sel = sw_reg[`SW_STACK_SEL_BIT];
    integer i;
    reg [DW-1:0] irq_stack_pointer_next;
    reg [DW-1:0] task_stack_pointer_next;
    reg [DW-1:0] vector_table_base_next;
    reg [DW-1:0] pc_next;
    reg [DW-1:0] sw_next;
    reg [DW-1:0] saved_instruction_pointer_next;
    reg [DW-1:0] saved_cpu_status_word_next;
    reg [DW-1:0] fast_irq_target_next;
    reg [DW-1:0] cr_rd_next;
    wire [DW-1:0] vec_offset;
    wire gpr_bank_wr;
    wire gpr_zero_wr;

    // ****************************************
    // decode helpers
    // ****************************************
    // register zero has no storage of its own, so every path tests for it
    function is_zero_idx;
        input [`GPR_IDX_W-1:0] idx;
        begin
            is_zero_idx = (idx == {`GPR_IDX_W{1'b0}});
        end
    endfunction

    function cr_hit;
        input en;
        input [`CR_SEL_W-1:0] sel;
        input [`CR_SEL_W-1:0] code;
        begin
            cr_hit = en && (sel == code);
        end
    endfunction

    // register zero maps to selected stack
    function [DW-1:0] bank_pick;
        input sel;
        input [DW-1:0] task_stack_pointer;
        input [DW-1:0] irq_stack_pointer;
        begin
            bank_pick = sel ? task_stack_pointer : irq_stack_pointer;
        end
    endfunction

    // any register read as data or address
    function [DW-1:0] gpr_read;
        input [`GPR_IDX_W-1:0] idx;
        input [DW-1:0] irq_stack_pointer;
        input [DW-1:0] task_stack_pointer;
        input sel;
        begin
            if (is_zero_idx(idx)) begin
                gpr_read = bank_pick(sel, task_stack_pointer, irq_stack_pointer);
            end else begin
                gpr_read = gpr_mem[idx];
            end
        end
    endfunction

    // ****************************************
    // read paths
    // ****************************************
    // register zero maps to selected stack
    assign stack_pointer = bank_pick(task_sel, task_stack_pointer_reg, irq_stack_pointer_reg);
    assign rd_a_data = gpr_read(rd_a_idx, irq_stack_pointer_reg, task_stack_pointer_reg,
                                task_sel);
    assign rd_b_data = gpr_read(rd_b_idx, irq_stack_pointer_reg, task_stack_pointer_reg,
                                task_sel);
    assign instruction_pointer = pc_reg;
    assign cpu_status_word = sw_reg;

    // ****************************************
    // vector table
    // ****************************************
    // vector lookup relative to base
    // top index bits fall off, so a huge index wraps inside the address space
    assign vec_offset = vec_index << `VEC_ENTRY_SHIFT;
    assign vec_entry_addr = vector_table_base_reg + vec_offset;

    // ****************************************
    // general-purpose registers
    // ****************************************
    // registers one to fifteen stored here
    assign gpr_bank_wr = gpr_wr_en && !is_zero_idx(gpr_wr_idx);
    assign gpr_zero_wr = gpr_wr_en && is_zero_idx(gpr_wr_idx);

    always @(posedge clk_sys) begin
        if (rst) begin
            for (i = 1; i < `GPR_COUNT; i = i + 1) begin
                gpr_mem[i] <= `ADDR_RESET;
            end
        end else if (gpr_bank_wr) begin
            gpr_mem[gpr_wr_idx] <= gpr_wr_data;
        end
    end

    // ****************************************
    // stack pointers
    // ****************************************
    // register-zero writes land only in the bank selected at write time; the
    // alignment to four is software's duty and is not forced here
    always @* begin
        irq_stack_pointer_next = irq_stack_pointer_reg;
        task_stack_pointer_next = task_stack_pointer_reg;
        if (gpr_zero_wr) begin
            if (task_sel) begin
                task_stack_pointer_next = gpr_wr_data;
            end else begin
                irq_stack_pointer_next = gpr_wr_data;
            end
        end
        // a control write names its bank directly and wins a same-cycle clash
        if (cr_hit(cr_wr_en, cr_wr_sel, `CR_ISP)) begin
            irq_stack_pointer_next = cr_wr_data;
        end
        if (cr_hit(cr_wr_en, cr_wr_sel, `CR_USP)) begin
            task_stack_pointer_next = cr_wr_data;
        end
    end

    // ****************************************
    // stack pointer flops
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst) begin
            irq_stack_pointer_reg <= `ADDR_RESET;
            task_stack_pointer_reg <= `ADDR_RESET;
        end else begin
            irq_stack_pointer_reg <= irq_stack_pointer_next;
            task_stack_pointer_reg <= task_stack_pointer_next;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // a fast interrupt outranks a same-cycle pc load or control write other than the two stack pointers so that the
    // saved copies always match the interrupted context
    always @* begin
        vector_table_base_next = vector_table_base_reg;
        pc_next = pc_reg;
        sw_next = sw_reg;
        saved_instruction_pointer_next = saved_instruction_pointer_reg;
        saved_cpu_status_word_next = saved_cpu_status_word_reg;
        fast_irq_target_next = fast_irq_target_reg;
        if (fast_irq_take) begin
            saved_instruction_pointer_next = pc_reg;
            // save status word bit for bit
            saved_cpu_status_word_next = sw_reg;
            pc_next = fast_irq_target_reg;
        end else begin
            if (pc_load_en) begin
                pc_next = pc_load_addr;
            end
            if (cr_wr_en) begin
                case (cr_wr_sel)
                    `CR_VTB: vector_table_base_next = cr_wr_data;
                    `CR_SW: sw_next = cr_wr_data;
                    `CR_SPC: saved_instruction_pointer_next = cr_wr_data;
                    `CR_SSW: saved_cpu_status_word_next = cr_wr_data;
                    `CR_FIT: fast_irq_target_next = cr_wr_data;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // control register flops
    // ****************************************
    always @(posedge clk_sys) begin
        if (rst) begin
            vector_table_base_reg <= `ADDR_RESET;
            pc_reg <= `ADDR_RESET;
            sw_reg <= `SW_RESET;
            saved_instruction_pointer_reg <= `ADDR_RESET;
            saved_cpu_status_word_reg <= `SW_RESET;
            fast_irq_target_reg <= `ADDR_RESET;
        end else begin
            vector_table_base_reg <= vector_table_base_next;
            pc_reg <= pc_next;
            sw_reg <= sw_next;
            saved_instruction_pointer_reg <= saved_instruction_pointer_next;
            saved_cpu_status_word_reg <= saved_cpu_status_word_next;
            fast_irq_target_reg <= fast_irq_target_next;
        end
    end

    // ****************************************
    // control register read port
    // ****************************************
    // the answer comes one cycle after the select so that the wide mux
    // does not sit in the caller's path
    always @* begin
        case (cr_rd_sel)
            `CR_ISP: cr_rd_next = irq_stack_pointer_reg;
            `CR_USP: cr_rd_next = task_stack_pointer_reg;
            `CR_VTB: cr_rd_next = vector_table_base_reg;
            `CR_SW: cr_rd_next = sw_reg;
            `CR_SPC: cr_rd_next = saved_instruction_pointer_reg;
            `CR_SSW: cr_rd_next = saved_cpu_status_word_reg;
            `CR_FIT: cr_rd_next = fast_irq_target_reg;
            default: cr_rd_next = pc_reg;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            cr_rd_data <= `ADDR_RESET;
        end else begin
            cr_rd_data <= cr_rd_next;
        end
    end

    // ****************************************
    // accumulator
    // ****************************************
    // kept in its own unit so the product tree stays apart from the register file
    // accumulator instance
    wide_product_sum_unit #(
        .DW(DW)
    ) acc_unit (
        .clk_sys(clk_sys),
        .rst(rst),
        .acc_op(acc_op),
        .acc_opnd_a(acc_opnd_a),
        .acc_opnd_b(acc_opnd_b),
        .wide_product_sum_reg(wide_product_sum_reg),
        .acc_upper_half(acc_upper_half),
        .acc_middle_half(acc_middle_half)
    );
endmodule

// *** core/cpu_regs_consts.vh ***
`ifndef CPU_REGS_CONSTS_VH
`define CPU_REGS_CONSTS_VH
`define GPR_COUNT 16
`define GPR_IDX_W 4
`define DATA_W 32
`define ACC_W 64
`define SW_STACK_SEL_BIT 17
`define SW_RESET 32'h00000000
`define ADDR_RESET 32'h00000000
`define ACC_RESET 64'h0000000000000000
`define ACC_HI_MSB 63
`define ACC_HI_LSB 32
`define ACC_LO_MSB 31
`define ACC_LO_LSB 0
`define ACC_MID_MSB 47
`define ACC_MID_LSB 16
`define VEC_ENTRY_SHIFT 2
`define ACC_OP_W 3
`define ACC_OP_NONE 3'h0
`define ACC_OP_WR_HI 3'h1
`define ACC_OP_WR_LO 3'h2
`define ACC_OP_SPROD 3'h3
`define ACC_OP_UPROD 3'h4
`define ACC_OP_PROD 3'h5
`define ACC_OP_RPSUM 3'h6
`define CR_SEL_W 3
`define CR_ISP 3'h0
`define CR_USP 3'h1
`define CR_VTB 3'h2
`define CR_SW 3'h3
`define CR_SPC 3'h4
`define CR_SSW 3'h5
`define CR_FIT 3'h6
`define CR_PC 3'h7
`endif

// *** core/wide_product_sum_unit.v ***
`timescale 1ns/1ns
`include "cpu_regs_consts.vh"
// ****************************************
// accumulator with half moves and products
// ****************************************
module wide_product_sum_unit #(
    parameter DW = `DATA_W
) (
    input wire clk_sys,
    input wire rst,
    input wire [`ACC_OP_W-1:0] acc_op,
    input wire [DW-1:0] acc_opnd_a,
    input wire [DW-1:0] acc_opnd_b,
    output reg [2*DW-1:0] wide_product_sum_reg,
    output wire [DW-1:0] acc_upper_half,
    output wire [DW-1:0] acc_middle_half
);
    reg [2*DW-1:0] wide_product_sum_next;
    wire [2*DW-1:0] sprod = $signed(acc_opnd_a) * $signed(acc_opnd_b);
    wire [2*DW-1:0] uprod = acc_opnd_a * acc_opnd_b;

    always @* begin
        wide_product_sum_next = wide_product_sum_reg;
        case (acc_op)
            `ACC_OP_WR_HI: wide_product_sum_next[`ACC_HI_MSB:`ACC_HI_LSB] = acc_opnd_a;
            `ACC_OP_WR_LO: wide_product_sum_next[`ACC_LO_MSB:`ACC_LO_LSB] = acc_opnd_a;
            `ACC_OP_SPROD: wide_product_sum_next = sprod;
            `ACC_OP_UPROD: wide_product_sum_next = uprod;
            // plain product keeps the signed result of the low word pair
            `ACC_OP_PROD: wide_product_sum_next = sprod;
            // one step of a repeated product-sum, issued per element pair
            `ACC_OP_RPSUM: wide_product_sum_next = wide_product_sum_reg + sprod;
            default: wide_product_sum_next = wide_product_sum_reg;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            wide_product_sum_reg <= `ACC_RESET;
        end else begin
            wide_product_sum_reg <= wide_product_sum_next;
        end
    end

    assign acc_upper_half = wide_product_sum_reg[`ACC_HI_MSB:`ACC_HI_LSB];
    assign acc_middle_half = wide_product_sum_reg[`ACC_MID_MSB:`ACC_MID_LSB];
endmodule

// *** tb/cpu_core_register_set_asserts.sv ***
`timescale 1ns/1ns
// ****************************************
// register set port checks
// ****************************************
module cpu_core_register_set_asserts (
    input wire clk_sys,
    input wire rst,
    input wire fast_irq_take,
    input wire pc_load_en,
    input wire [31:0] pc_load_addr,
    input wire [2:0] cr_rd_sel,
    input wire [31:0] cr_rd_data,
    input wire [31:0] instruction_pointer,
    input wire [31:0] cpu_status_word,
    input wire [2:0] acc_op,
    input wire [31:0] acc_opnd_a,
    input wire [31:0] acc_opnd_b,
    input wire [63:0] wide_product_sum_reg,
    input wire [31:0] acc_upper_half,
    input wire [31:0] acc_middle_half
);
    wire [63:0] acc = wide_product_sum_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // saved copies are read back one cycle after the take
    sequence s_take_read(logic [2:0] sel);
        fast_irq_take ##1 cr_rd_sel == sel;
    endsequence
    AST_ACC_WR_HI: assert property (
        acc_op == 3'h1 |=> acc[63:32] == $past(acc_opnd_a) && $stable(acc[31:0]))
        else $error("upper write wrong");
    AST_ACC_WR_LO: assert property (
        acc_op == 3'h2 |=> acc[31:0] == $past(acc_opnd_a) && $stable(acc[63:32]))
        else $error("lower write wrong");
    AST_ACC_READS: assert property (
        acc_upper_half == acc[63:32] && acc_middle_half == acc[47:16])
        else $error("half reads wrong");
    AST_ACC_SPROD: assert property (
        (acc_op == 3'h3 || acc_op == 3'h5) |=>
        $signed(acc) == $signed($past(acc_opnd_a)) * $signed($past(acc_opnd_b)))
        else $error("signed product wrong");
    AST_FIQ_BRANCH: assert property (
        fast_irq_take && cr_rd_sel == 3'h6 |=> instruction_pointer == cr_rd_data)
        else $error("fast branch wrong");
    AST_FIQ_SAVE_PC: assert property (
        s_take_read(3'h4) |=> cr_rd_data == $past(instruction_pointer, 2))
        else $error("saved pc wrong");
    AST_FIQ_SAVE_SW: assert property (
        s_take_read(3'h5) |=> cr_rd_data == $past(cpu_status_word, 2))
        else $error("saved status wrong");
    AST_PC_LOAD: assert property (
        pc_load_en && !fast_irq_take |=> instruction_pointer == $past(pc_load_addr))
        else $error("pc load wrong");
endmodule
bind cpu_core_register_set cpu_core_register_set_asserts i_chk (.*);

// *** tb/core_exec_model.sv ***
`timescale 1ns/1ns
module core_exec_model (
    input wire clk_sys,
    output reg gpr_wr_en = 1'b0,
    output reg [3:0] gpr_wr_idx = 4'h0,
    output reg [31:0] gpr_wr_data = 32'h0,
    output reg cr_wr_en = 1'b0,
    output reg [2:0] cr_wr_sel = 3'h0,
    output reg [31:0] cr_wr_data = 32'h0,
    output reg pc_load_en = 1'b0,
    output reg [31:0] pc_load_addr = 32'h0,
    output reg fast_irq_take = 1'b0,
    output reg [2:0] acc_op = 3'h0,
    output reg [31:0] acc_opnd_a = 32'h0,
    output reg [31:0] acc_opnd_b = 32'h0
);
    // one-cycle strobes; stale write data is scrambled so it cannot pass for valid
    task fin;
        @(negedge clk_sys);
        {gpr_wr_en, cr_wr_en, pc_load_en, fast_irq_take} <= 4'h0;
        acc_op <= 3'h0;
        {gpr_wr_data, cr_wr_data} <= ~{gpr_wr_data, cr_wr_data};
    endtask
    task wr_gpr(input [3:0] i, input [31:0] d);
        @(negedge clk_sys);
        {gpr_wr_en, gpr_wr_idx, gpr_wr_data} <= {1'b1, i, d};
        fin;
    endtask
    task wr_cr(input [2:0] s, input [31:0] d);
        @(negedge clk_sys);
        {cr_wr_en, cr_wr_sel} <= {1'b1, s};
        cr_wr_data <= (s < 3'h2) ? d & ~32'h3 : d;
        fin;
    endtask
    task load_pc(input [31:0] a);
        @(negedge clk_sys);
        {pc_load_en, pc_load_addr} <= {1'b1, a};
        fin;
    endtask
    task fiq;
        @(negedge clk_sys);
        fast_irq_take <= 1'b1;
        fin;
    endtask
    task acc_do(input [2:0] op, input [31:0] a, input [31:0] b);
        @(negedge clk_sys);
        {acc_op, acc_opnd_a, acc_opnd_b} <= {op, a, b};
        fin;
    endtask
endmodule

// *** tb/cpu_core_register_set_bench.sv ***
`timescale 1ns/1ns
module cpu_core_register_set_bench;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [3:0] rd_a_idx = 4'h0;
    reg [3:0] rd_b_idx = 4'h0;
    reg [2:0] cr_rd_sel = 3'h0;
    reg [31:0] vec_index = 32'h0;
    wire gpr_wr_en, cr_wr_en, pc_load_en, fast_irq_take;
    wire [3:0] gpr_wr_idx;
    wire [2:0] cr_wr_sel, acc_op;
    wire [31:0] gpr_wr_data, cr_wr_data, pc_load_addr, acc_opnd_a, acc_opnd_b;
    wire [31:0] rd_a_data, rd_b_data, cr_rd_data, vec_entry_addr, stack_pointer;
    wire [31:0] acc_upper_half, acc_middle_half, instruction_pointer, cpu_status_word;
    wire [63:0] wide_product_sum_reg;
    integer n_mismatch = 0;
    integer checks_done = 0;
    always #2 clk_sys = ~clk_sys;
    cpu_core_register_set i_cpu_core_register_set (.*);
    core_exec_model m (.*);
    task chk(input [63:0] got, input [63:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // called at a falling edge; the registered read answers one cycle later
    task rd_cr(input [2:0] s, input [31:0] exp);
        cr_rd_sel = s;
        @(negedge clk_sys);
        chk(cr_rd_data, exp);
    endtask
    task t_gpr;
        integer i;
        for (i = 1; i < 16; i = i + 1) m.wr_gpr(i[3:0], 32'hC0DE0000 + i);
        for (i = 1; i < 16; i = i + 1) begin
            rd_a_idx = i[3:0];
            rd_b_idx = 4'h0 - i[3:0];
            @(negedge clk_sys);
            chk(rd_a_data, 32'hC0DE0000 + i);
            chk(rd_b_data, 32'hC0DE0010 - i);
        end
        $display("test gpr done");
    endtask
    task t_stack;
        m.wr_cr(3'h0, 32'h100);
        m.wr_cr(3'h1, 32'h204);
        rd_a_idx = 4'h0;
        @(negedge clk_sys);
        chk(rd_a_data, 32'h100);
        m.wr_cr(3'h3, 32'h20000);
        chk(stack_pointer, 32'h204);
        chk(cpu_status_word, 32'h20000);
        m.wr_gpr(4'h0, 32'h308);
        rd_cr(3'h1, 32'h308);
        rd_cr(3'h0, 32'h100);
        $display("test stack done");
    endtask
    task t_vec;
        m.wr_cr(3'h2, 32'h1000);
        vec_index = 32'h3FF;
        @(negedge clk_sys);
        chk(vec_entry_addr, 32'h1FFC);
        $display("test vector done");
    endtask
    task t_acc;
        m.acc_do(3'h1, 32'h12345678, 32'h0);
        m.acc_do(3'h2, 32'h9ABCDEF0, 32'h0);
        chk(wide_product_sum_reg, 64'h123456789ABCDEF0);
        chk({acc_upper_half, acc_middle_half}, 64'h1234567856789ABC);
        m.acc_do(3'h1, 32'hFFFFFFFF, 32'h0);
        chk(wide_product_sum_reg, 64'hFFFFFFFF9ABCDEF0);
        m.acc_do(3'h4, 32'hFFFFFFFF, 32'h2);
        chk(wide_product_sum_reg, 64'h1FFFFFFFE);
        m.acc_do(3'h3, 32'hFFFFFFFF, 32'h2);
        chk(wide_product_sum_reg, 64'hFFFFFFFFFFFFFFFE);
        m.acc_do(3'h5, 32'hFFFFFFFE, 32'h3);
        chk(wide_product_sum_reg, 64'hFFFFFFFFFFFFFFFA);
        m.acc_do(3'h6, 32'h3, 32'h4);
        chk(wide_product_sum_reg, 64'h6);
        $display("test accumulator done");
    endtask
    task t_fiq;
        m.load_pc(32'h400);
        chk(instruction_pointer, 32'h400);
        m.wr_cr(3'h6, 32'h800);
        cr_rd_sel = 3'h6;
        m.fiq;
        chk(instruction_pointer, 32'h800);
        rd_cr(3'h4, 32'h400);
        m.load_pc(32'h44C);
        m.fiq;
        rd_cr(3'h5, 32'h20000);
        $display("test fast irq done");
    endtask
    // writes issued while reset is high must not land
    task t_reset;
        rst = 1'b1;
        m.wr_gpr(4'h1, 32'h0000AAAA);
        m.load_pc(32'h00000ABC);
        rst = 1'b0;
        rd_a_idx = 4'h1;
        @(negedge clk_sys);
        chk(rd_a_data, 32'h0);
        chk(instruction_pointer, 32'h0);
        chk(wide_product_sum_reg, 64'h0);
        chk(cpu_status_word, 32'h0);
        chk(cr_rd_data, 32'h0);
        $display("test reset done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        chk({wide_product_sum_reg[31:0], instruction_pointer}, 64'h0);
        t_gpr;
        t_stack;
        t_vec;
        t_acc;
        t_fiq;
        t_reset;
        test_done;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch = n_mismatch + 1;
        test_done;
    end
endmodule
